// file: hdl/frs_regs.svh
`ifndef FRS_REGS_SVH
`define FRS_REGS_SVH
// frequencies are in 0.01 Hz units (signed 24 bit)
`define FRS_FW 24
`define FRS_PRESET_DEF 24'h001388
`define FRS_MAX_DEF 24'h001388
`define FRS_UL_DEF 24'h001388
`define FRS_ZERO_F 24'h000000
`define FRS_MAX_LO 24'h001388
`define FRS_MAX_HI_01 24'h04E200
`define FRS_MAX_HI_001 24'h00C350
`define FRS_FULL_SCALE 16'h03E8
`define FRS_PCT_FULL 16'h0064
`define FRS_PCT_MAX 16'h0096
`define FRS_RES_01 2'h1
`endif

// file: hdl/frs_pkg.sv
package frs_pkg;
    typedef enum logic [2:0] {
        FRS_SEL_MAIN = 3'h0,
        FRS_SEL_OP = 3'h1,
        FRS_SEL_MAIN_AUX = 3'h2,
        FRS_SEL_MAIN_OP = 3'h3,
        FRS_SEL_AUX_OP = 3'h4
    } frs_src_t;
    typedef enum logic [1:0] {
        FRS_OP_ADD = 2'h0,
        FRS_OP_SUB = 2'h1,
        FRS_OP_MAX = 2'h2,
        FRS_OP_MIN = 2'h3
    } frs_op_t;
    typedef enum logic [2:0] {
        FRS_UL_FIXED = 3'h0,
        FRS_UL_AN1 = 3'h1,
        FRS_UL_AN2 = 3'h2,
        FRS_UL_AN3 = 3'h3,
        FRS_UL_PULSE = 3'h4,
        FRS_UL_COMM = 3'h5
    } frs_ul_src_t;
    typedef enum logic [1:0] {
        FRS_LL_STOP = 2'h0,
        FRS_LL_RUN_LOWER = 2'h1,
        FRS_LL_ZERO = 2'h2
    } frs_ll_act_t;
endpackage

// file: hdl/frs_scale.sv
`timescale 1ns/1ps
`default_nettype none
`include "frs_regs.svh"
// registered multiply: y = a * num / den
module frs_scale #(
    parameter int W = 24,
    parameter logic [15:0] DEN = 16'h03E8
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // operands
    input wire logic [W-1:0] a,
    input wire logic [15:0] num,
    // result
    output logic [W-1:0] y
);
    logic [W+15:0] prod;
    logic [W+15:0] quot;
    assign prod = a * num;
    assign quot = prod / DEN;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            y <= '0;
        end else begin
            y <= quot[W-1:0];
        end
    end
endmodule // frs_scale
`default_nettype wire

// file: hdl/frs_selector.sv
`timescale 1ns/1ps
`default_nettype none
`include "frs_regs.svh"
// Notes on behaviour
// - digit 0: main reference alone
// - digit 1: operation result is target
// - digit 2: switch terminal picks main/aux
// - digit 3: switch picks main/operation result
// - digit 4: switch picks aux/operation result
// - operator 0: main plus auxiliary
// - operator 1: main minus auxiliary
// - operator 2: larger absolute value
// - operator 3: smaller absolute value
// - offset added to every operation result
// - preset frequency loads digital reference
// - direction setting inverts motor direction
// - parameter init restores normal direction
// - full scale input maps to max
// - max frequency range per resolution
// - upper limit source selector, default fixed
// - analog 100% equals fixed upper limit
// - reference held at upper limit
// - fixed upper limit between lower and max
// - offset added to analog/pulse upper limit
// - below lower limit: stop/lower/zero
// - auxiliary range relative max or main
// - stop memory keeps or discards adjustments
module frs_selector (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // selection settings
    input wire logic [2:0] source_combine_select,
    input wire logic [1:0] combine_operator,
    input wire logic source_switch_pin,
    input wire logic main_is_digital,
    input wire logic aux_is_analog,
    // references, signed 0.01 Hz; analog in 0.1 % of full scale
    input wire logic [23:0] main_reference,
    input wire logic [15:0] aux_analog,
    input wire logic [23:0] aux_offset_frequency,
    input wire logic aux_range_base,
    input wire logic [15:0] aux_range_percent,
    // digital reference
    input wire logic [23:0] preset_frequency,
    input wire logic preset_load,
    input wire logic up_pulse,
    input wire logic down_pulse,
    input wire logic [23:0] updown_step,
    input wire logic running,
    input wire logic stop_memory_select,
    // direction
    input wire logic direction_invert,
    input wire logic param_init,
    // limits
    input wire logic [1:0] frequency_resolution,
    input wire logic [23:0] max_frequency,
    input wire logic [2:0] upper_limit_source,
    input wire logic [23:0] upper_limit_value,
    input wire logic [23:0] upper_limit_offset,
    input wire logic [23:0] lower_limit_value,
    input wire logic [15:0] analog_input_first,
    input wire logic [15:0] analog_input_second,
    input wire logic [15:0] analog_input_third,
    input wire logic [15:0] pulse_input,
    input wire logic [23:0] comm_upper_limit,
    input wire logic [1:0] below_lower_limit_action,
    // results
    output logic [23:0] target_frequency,
    output logic reverse_out,
    output logic stop_request,
    output logic [23:0] upper_limit_eff
);
    // ========================================
    // helpers
    function automatic logic [23:0] abs24(input logic [23:0] v);
        abs24 = v[23] ? 24'(-v) : v;
    endfunction
    function automatic logic [23:0] clamp(input logic [23:0] v, input logic [23:0] lo, input logic [23:0] hi);
        if ($signed(v) < $signed(lo)) clamp = lo;
        else if ($signed(v) > $signed(hi)) clamp = hi;
        else clamp = v;
    endfunction

    // ========================================
    // input synchronisers
    // terminal pins: source switch, up and down keys
    logic sw_s1_r, sw_s2_r, up_s1_r, up_s2_r, dn_s1_r, dn_s2_r;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sw_s1_r <= 1'b0;
            sw_s2_r <= 1'b0;
            up_s1_r <= 1'b0;
            up_s2_r <= 1'b0;
            dn_s1_r <= 1'b0;
            dn_s2_r <= 1'b0;
        end else begin
            sw_s1_r <= source_switch_pin;
            sw_s2_r <= sw_s1_r;
            up_s1_r <= up_pulse;
            up_s2_r <= up_s1_r;
            dn_s1_r <= down_pulse;
            dn_s2_r <= dn_s1_r;
        end
    end

    // ========================================
    // maximum frequency legal range
    logic [23:0] max_hi, max_eff;
    always_comb begin
        max_hi = (frequency_resolution == `FRS_RES_01) ? `FRS_MAX_HI_01 : `FRS_MAX_HI_001;
        max_eff = clamp(max_frequency, `FRS_MAX_LO, max_hi);
    end

    // ========================================
    // digital reference with up/down and stop memory
    logic [23:0] digital_r;
    logic running_d_r;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            digital_r <= `FRS_PRESET_DEF;
            running_d_r <= 1'b0;
        end else begin
            running_d_r <= running;
            if (preset_load) begin
                digital_r <= clamp(preset_frequency, `FRS_ZERO_F, max_eff);
            end else if (running_d_r && !running && !stop_memory_select) begin
                digital_r <= clamp(preset_frequency, `FRS_ZERO_F, max_eff);
            end else if (up_s2_r && !dn_s2_r) begin
                digital_r <= clamp(24'(digital_r + updown_step), `FRS_ZERO_F, max_eff);
            end else if (dn_s2_r && !up_s2_r) begin
                digital_r <= clamp(24'(digital_r - updown_step), `FRS_ZERO_F, max_eff);
            end
        end
    end

    // ========================================
    // auxiliary scaling (range base and percent)
    logic [23:0] aux_base, aux_full, aux_ref, aux_pct;
    logic [15:0] pct_lim;
    assign pct_lim = (aux_range_percent > `FRS_PCT_MAX) ? `FRS_PCT_MAX : aux_range_percent;
    assign aux_base = aux_range_base ? abs24(main_reference) : max_eff;
    frs_scale #(.W(24), .DEN(`FRS_FULL_SCALE)) u_aux_fs (
        .core_clk(core_clk),
        .resetn(resetn),
        .a(aux_base),
        .num(aux_analog),
        .y(aux_full)
    );
    frs_scale #(.W(24), .DEN(`FRS_PCT_FULL)) u_aux_pct (
        .core_clk(core_clk),
        .resetn(resetn),
        .a(aux_full),
        .num(pct_lim),
        .y(aux_pct)
    );
    assign aux_ref = aux_is_analog ? aux_pct : digital_r;

    // ========================================
    // main/aux operation and source selection
    logic [23:0] main_ref, op_res, sel_ref;
    logic [23:0] am, aa;
    assign main_ref = main_is_digital ? digital_r : main_reference;
    always_comb begin
        am = abs24(main_ref);
        aa = abs24(aux_ref);
        case (frs_pkg::frs_op_t'(combine_operator))
            frs_pkg::FRS_OP_ADD: op_res = 24'(main_ref + aux_ref);
            frs_pkg::FRS_OP_SUB: op_res = 24'(main_ref - aux_ref);
            frs_pkg::FRS_OP_MAX: op_res = (am > aa) ? am : aa;
            frs_pkg::FRS_OP_MIN: op_res = (am < aa) ? am : aa;
            default: op_res = main_ref;
        endcase
        op_res = 24'(op_res + aux_offset_frequency);
        case (frs_pkg::frs_src_t'(source_combine_select))
            frs_pkg::FRS_SEL_MAIN: sel_ref = main_ref;
            frs_pkg::FRS_SEL_OP: sel_ref = op_res;
            frs_pkg::FRS_SEL_MAIN_AUX: sel_ref = sw_s2_r ? aux_ref : main_ref;
            frs_pkg::FRS_SEL_MAIN_OP: sel_ref = sw_s2_r ? op_res : main_ref;
            frs_pkg::FRS_SEL_AUX_OP: sel_ref = sw_s2_r ? op_res : aux_ref;
            default: sel_ref = main_ref;
        endcase
    end

    // ========================================
    // upper limit
    logic [23:0] ul_fixed, ul_an_in, ul_an, ul_raw, ll_eff;
    logic [15:0] an_sel;
    always_comb begin
        ul_fixed = clamp(upper_limit_value, lower_limit_value, max_eff);
        case (frs_pkg::frs_ul_src_t'(upper_limit_source))
            frs_pkg::FRS_UL_AN1: an_sel = analog_input_first;
            frs_pkg::FRS_UL_AN2: an_sel = analog_input_second;
            frs_pkg::FRS_UL_AN3: an_sel = analog_input_third;
            default: an_sel = pulse_input;
        endcase
    end
    frs_scale #(.W(24), .DEN(`FRS_FULL_SCALE)) u_ul_fs (
        .core_clk(core_clk),
        .resetn(resetn),
        .a(ul_fixed),
        .num(an_sel),
        .y(ul_an_in)
    );
    assign ul_an = 24'(ul_an_in + upper_limit_offset);
    always_comb begin
        case (frs_pkg::frs_ul_src_t'(upper_limit_source))
            frs_pkg::FRS_UL_FIXED: ul_raw = ul_fixed;
            frs_pkg::FRS_UL_COMM: ul_raw = comm_upper_limit;
            default: ul_raw = ul_an;
        endcase
        ul_raw = clamp(ul_raw, `FRS_ZERO_F, max_eff);
        ll_eff = clamp(lower_limit_value, `FRS_ZERO_F, ul_raw);
    end

    // ========================================
    // final target, limits and direction
    logic [23:0] mag, tgt_nxt;
    logic stop_nxt, rev_r, dir_d_r;
    always_comb begin
        mag = abs24(sel_ref);
        stop_nxt = 1'b0;
        if (mag > ul_raw) begin
            tgt_nxt = ul_raw;
        end else if (mag < ll_eff) begin
            case (frs_pkg::frs_ll_act_t'(below_lower_limit_action))
                frs_pkg::FRS_LL_STOP: begin
                    tgt_nxt = `FRS_ZERO_F;
                    stop_nxt = 1'b1;
                end
                frs_pkg::FRS_LL_RUN_LOWER: tgt_nxt = ll_eff;
                default: tgt_nxt = `FRS_ZERO_F;
            endcase
        end else begin
            tgt_nxt = mag;
        end
    end
    // direction is taken only when the setting is written anew, so an init stays in force
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rev_r <= 1'b0;
            dir_d_r <= 1'b0;
        end else begin
            dir_d_r <= direction_invert;
            if (param_init) begin
                rev_r <= 1'b0;
            end else if (direction_invert != dir_d_r) begin
                rev_r <= direction_invert;
            end
        end
    end
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            target_frequency <= `FRS_ZERO_F;
            reverse_out <= 1'b0;
            stop_request <= 1'b0;
            upper_limit_eff <= `FRS_UL_DEF;
        end else begin
            target_frequency <= tgt_nxt;
            reverse_out <= rev_r ^ sel_ref[23];
            stop_request <= stop_nxt;
            upper_limit_eff <= ul_raw;
        end
    end

    // ========================================
    // checks
    property p_upper_hold;
        @(posedge core_clk) disable iff (!resetn)
        1'b1 |=> ($signed(target_frequency) <= $signed($past(ul_raw)));
    endproperty
    a_upper_hold: assert property (p_upper_hold) else $error("target above upper limit");
    property p_init_dir;
        @(posedge core_clk) disable iff (!resetn)
        param_init |=> ##1 (reverse_out == $past(sel_ref[23]));
    endproperty
    a_init_dir: assert property (p_init_dir) else $error("direction not restored");
    property p_main_only;
        @(posedge core_clk) disable iff (!resetn)
        (source_combine_select == 3'h0 && abs24(main_ref) <= ul_raw && abs24(main_ref) >= ll_eff)
        |=> target_frequency == abs24($past(main_ref));
    endproperty
    a_main_only: assert property (p_main_only) else $error("main not selected");
    property p_stop;
        @(posedge core_clk) disable iff (!resetn)
        stop_request |-> target_frequency == `FRS_ZERO_F;
    endproperty
    a_stop: assert property (p_stop) else $error("stop with nonzero target");
    property p_max;
        @(posedge core_clk) disable iff (!resetn)
        1'b1 |=> upper_limit_eff <= $past(max_hi);
    endproperty
    a_max: assert property (p_max) else $error("upper limit over max range");
    property p_switch_aux;
        @(posedge core_clk) disable iff (!resetn)
        (source_combine_select == 3'h2 && sw_s2_r && abs24(aux_ref) <= ul_raw && abs24(aux_ref) >= ll_eff)
        |=> target_frequency == abs24($past(aux_ref));
    endproperty
    a_switch_aux: assert property (p_switch_aux) else $error("auxiliary not selected by switch");
    property p_op_result;
        @(posedge core_clk) disable iff (!resetn)
        (source_combine_select == 3'h1 && abs24(op_res) <= ul_raw && abs24(op_res) >= ll_eff)
        |=> target_frequency == abs24($past(op_res));
    endproperty
    a_op_result: assert property (p_op_result) else $error("operation result not selected");
    property p_run_lower;
        @(posedge core_clk) disable iff (!resetn)
        (below_lower_limit_action == 2'h1 && abs24(sel_ref) < ll_eff)
        |=> target_frequency == $past(ll_eff);
    endproperty
    a_run_lower: assert property (p_run_lower) else $error("not running at lower limit");
    property p_lower_zero;
        @(posedge core_clk) disable iff (!resetn)
        (below_lower_limit_action == 2'h2 && abs24(sel_ref) < ll_eff)
        |=> (target_frequency == `FRS_ZERO_F && !stop_request);
    endproperty
    a_lower_zero: assert property (p_lower_zero) else $error("zero speed action wrong");
    property p_stop_revert;
        @(posedge core_clk) disable iff (!resetn)
        (running_d_r && !running && !stop_memory_select && !preset_load)
        |=> digital_r == $past(clamp(preset_frequency, `FRS_ZERO_F, max_eff));
    endproperty
    a_stop_revert: assert property (p_stop_revert) else $error("digital reference not reverted");
    property p_upper_fixed;
        @(posedge core_clk) disable iff (!resetn)
        upper_limit_source == 3'h0 |=> upper_limit_eff == $past(clamp(ul_fixed, `FRS_ZERO_F, max_eff));
    endproperty
    a_upper_fixed: assert property (p_upper_fixed) else $error("fixed upper limit not used");
endmodule // frs_selector
`default_nettype wire

// file: bench/frequency_reference_selector_bench.sv
`timescale 1ns/1ps
`default_nettype none
module frequency_reference_selector_bench;
// ==========================================================
// stimulus and observed signals
logic core_clk = 1'b0, resetn = 1'b0;
logic [2:0] source_combine_select = 3'h0, upper_limit_source = 3'h0;
logic [1:0] combine_operator = 2'h0, frequency_resolution = 2'h1, below_lower_limit_action = 2'h1;
logic source_switch_pin = 1'b0, main_is_digital = 1'b0, aux_is_analog = 1'b1, aux_range_base = 1'b0;
logic preset_load = 1'b0, up_pulse = 1'b0, down_pulse = 1'b0, running = 1'b1, stop_memory_select = 1'b0;
logic direction_invert = 1'b0, param_init = 1'b0;
logic [23:0] main_reference = 24'h0, aux_offset_frequency = 24'h0, preset_frequency = 24'h0;
logic [23:0] updown_step = 24'h000064, max_frequency = 24'h0, upper_limit_value = 24'h0;
logic [23:0] upper_limit_offset = 24'h0, lower_limit_value = 24'h0, comm_upper_limit = 24'h0;
logic [15:0] aux_analog = 16'h0, aux_range_percent = 16'h0, analog_input_first = 16'h0;
logic [15:0] analog_input_second = 16'h0, analog_input_third = 16'h0, pulse_input = 16'h0;
logic [23:0] target_frequency, upper_limit_eff;
logic reverse_out, stop_request;
int failures = 0, num_checks = 0;
always #10 core_clk = ~core_clk;
frs_selector u_dut (.core_clk(core_clk), .resetn(resetn), .source_combine_select(source_combine_select),
    .combine_operator(combine_operator), .source_switch_pin(source_switch_pin), .main_is_digital(main_is_digital),
    .aux_is_analog(aux_is_analog), .main_reference(main_reference), .aux_analog(aux_analog),
    .aux_offset_frequency(aux_offset_frequency), .aux_range_base(aux_range_base),
    .aux_range_percent(aux_range_percent), .preset_frequency(preset_frequency), .preset_load(preset_load),
    .up_pulse(up_pulse), .down_pulse(down_pulse), .updown_step(updown_step), .running(running),
    .stop_memory_select(stop_memory_select), .direction_invert(direction_invert), .param_init(param_init),
    .frequency_resolution(frequency_resolution), .max_frequency(max_frequency),
    .upper_limit_source(upper_limit_source), .upper_limit_value(upper_limit_value),
    .upper_limit_offset(upper_limit_offset), .lower_limit_value(lower_limit_value),
    .analog_input_first(analog_input_first), .analog_input_second(analog_input_second),
    .analog_input_third(analog_input_third), .pulse_input(pulse_input), .comm_upper_limit(comm_upper_limit),
    .below_lower_limit_action(below_lower_limit_action), .target_frequency(target_frequency),
    .reverse_out(reverse_out), .stop_request(stop_request), .upper_limit_eff(upper_limit_eff));
// ==========================================================
// helpers
task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
        failures++;
        $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
endtask
task automatic settle();
    repeat (6) @(negedge core_clk);
endtask
task automatic base();
    source_combine_select = 3'h0; combine_operator = 2'h0; source_switch_pin = 1'b0;
    main_is_digital = 1'b0; aux_is_analog = 1'b1; aux_range_base = 1'b0; aux_range_percent = 16'h0064;
    main_reference = 24'h000BB8; aux_analog = 16'h0064; aux_offset_frequency = 24'h0; direction_invert = 1'b0;
    frequency_resolution = 2'h1; max_frequency = 24'h0186A0; upper_limit_source = 3'h0;
    upper_limit_value = 24'h0186A0; upper_limit_offset = 24'h0; lower_limit_value = 24'h0;
    below_lower_limit_action = 2'h1; running = 1'b1; stop_memory_select = 1'b0;
endtask
task automatic step(input logic up, input logic dn);
    up_pulse = up;
    down_pulse = dn;
    @(negedge core_clk);
    up_pulse = 1'b0;
    down_pulse = 1'b0;
    settle();
endtask
task test_done();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
endtask
// ==========================================================
// scenarios
task automatic test_digital();
    base();
    main_is_digital = 1'b1;
    settle();
    check("preset default", target_frequency, 24'h001388);
    preset_frequency = 24'h0007D0;
    preset_load = 1'b1;
    @(negedge core_clk);
    preset_load = 1'b0;
    settle();
    check("preset load", target_frequency, 24'h0007D0);
    step(1'b1, 1'b0);
    check("up step", target_frequency, 24'h000834);
    running = 1'b0;
    settle();
    check("stop discards", target_frequency, 24'h0007D0);
    stop_memory_select = 1'b1;
    running = 1'b1;
    step(1'b1, 1'b0);
    step(1'b1, 1'b0);
    step(1'b0, 1'b1);
    running = 1'b0;
    settle();
    check("stop keeps", target_frequency, 24'h000834);
    $display("test digital done");
endtask
task automatic test_sources();
    logic [23:0] e_off [5];
    logic [23:0] e_on [5];
    e_off = '{24'h000BB8, 24'h0032C8, 24'h000BB8, 24'h000BB8, 24'h002710};
    e_on = '{24'h000BB8, 24'h0032C8, 24'h002710, 24'h0032C8, 24'h0032C8};
    base();
    for (int d = 0; d < 5; d++) begin
        source_combine_select = 3'(d);
        source_switch_pin = 1'b0;
        settle();
        check("source sw0", target_frequency, e_off[d]);
        source_switch_pin = 1'b1;
        settle();
        check("source sw1", target_frequency, e_on[d]);
    end
    source_combine_select = 3'h0;
    settle();
    main_reference = 24'h000C1C;
    @(negedge core_clk);
    check("one cycle answer", target_frequency, 24'h000C1C);
    $display("test sources done");
endtask
task automatic test_ops();
    logic [23:0] e_op [4];
    e_op = '{24'h001B58, 24'h0032C8, 24'h002710, 24'h000BB8};
    base();
    source_combine_select = 3'h1;
    main_reference = 24'hFFF448;
    for (int o = 0; o < 4; o++) begin
        combine_operator = 2'(o);
        settle();
        check("operator", target_frequency, e_op[o]);
        check("operator sign", {23'h0, reverse_out}, {23'h0, o == 1});
    end
    combine_operator = 2'h0;
    aux_offset_frequency = 24'h0001F4;
    settle();
    check("offset", target_frequency, 24'h001D4C);
    source_combine_select = 3'h0;
    settle();
    check("no offset main", target_frequency, 24'h000BB8);
    check("reverse", {23'h0, reverse_out}, 24'h1);
    direction_invert = 1'b1;
    settle();
    check("inverted", {23'h0, reverse_out}, 24'h0);
    param_init = 1'b1;
    @(negedge core_clk);
    param_init = 1'b0;
    settle();
    check("init restores", {23'h0, reverse_out}, 24'h1);
    $display("test ops done");
endtask
task automatic test_upper();
    logic [23:0] e_ul [6];
    e_ul = '{24'h000FA0, 24'h000834, 24'h00044C, 24'h000C1C, 24'h001004, 24'h0009C4};
    base();
    main_reference = 24'h001770;
    upper_limit_value = 24'h000FA0;
    upper_limit_offset = 24'h000064;
    analog_input_first = 16'h01F4;
    analog_input_second = 16'h00FA;
    analog_input_third = 16'h02EE;
    pulse_input = 16'h03E8;
    comm_upper_limit = 24'h0009C4;
    for (int s = 0; s < 6; s++) begin
        upper_limit_source = 3'(s);
        settle();
        check("upper limit", upper_limit_eff, e_ul[s]);
        check("held at upper", target_frequency, e_ul[s]);
    end
    $display("test upper done");
endtask
task automatic test_lower();
    logic [23:0] e_t [3];
    e_t = '{24'h0, 24'h0007D0, 24'h0};
    base();
    main_reference = 24'h0003E8;
    lower_limit_value = 24'h0007D0;
    for (int a = 0; a < 3; a++) begin
        below_lower_limit_action = 2'(a);
        settle();
        check("below lower", target_frequency, e_t[a]);
        check("stop flag", {23'h0, stop_request}, {23'h0, a == 0});
    end
    $display("test lower done");
endtask
task automatic test_max();
    base();
    source_combine_select = 3'h4;
    aux_analog = 16'h03E8;
    frequency_resolution = 2'h2;
    settle();
    check("max 0.01", target_frequency, 24'h00C350);
    frequency_resolution = 2'h1;
    max_frequency = 24'h061A80;
    upper_limit_value = 24'h061A80;
    settle();
    check("max 0.1", target_frequency, 24'h04E200);
    max_frequency = 24'h0003E8;
    settle();
    check("max floor", target_frequency, 24'h001388);
    aux_range_base = 1'b1;
    aux_range_percent = 16'h0096;
    max_frequency = 24'h0186A0;
    main_reference = 24'h0007D0;
    settle();
    check("aux rel main", target_frequency, 24'h000BB8);
    aux_range_percent = 16'h00C8;
    settle();
    check("aux pct clamp", target_frequency, 24'h000BB8);
    $display("test max done");
endtask
// ==========================================================
// main sequence
initial begin
    base();
    repeat (12) @(negedge core_clk);
    check("reset target", target_frequency, 24'h0);
    check("reset reverse", {23'h0, reverse_out}, 24'h0);
    check("reset stop", {23'h0, stop_request}, 24'h0);
    check("reset upper", upper_limit_eff, 24'h001388);
    resetn = 1'b1;
    test_digital();
    test_sources();
    test_ops();
    test_upper();
    test_lower();
    test_max();
    test_done();
end
initial begin
    #1000000;
    failures++;
    test_done();
end
endmodule // frequency_reference_selector_bench
`default_nettype wire
